// *** bench/servo_axis_enable_limit_logic_assertions.sv ***
// Checker of bus, enable and stop outputs of the servo axis block
`timescale 1ns/1ps
`default_nettype none
module servo_axis_enable_limit_logic_assertions (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Axis
  input wire logic        limitPos,
  input wire logic        limitNeg,
  input wire logic        ampFault,
  input wire logic        ampEnable_n,
  input wire logic        motionRun,
  input wire logic        stopDecel,
  input wire logic        stopAbrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [3:0] calm_ff;
  logic [3:0] nxt_calm;
  logic       take;
  logic       cmdWr;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmdWr = take && wb_we_i && wb_adr_i == servo_axis_pkg::CMD_OFS && wb_sel_i[0];
  // Input history, so enable is only judged with quiet inputs
  always_comb nxt_calm = {calm_ff[2:0], ampFault | limitPos | limitNeg};
  always_ff @(posedge clk_sys) calm_ff <= nxt_calm;
  AST_RESET_OFF: assert property (disable iff (1'b0) !rst_n |=> ampEnable_n)
    else $error("enable output active after reset");
  AST_ENABLE: assert property (cmdWr && wb_dat_i[0] && !wb_dat_i[1] && calm_ff == 4'h0
    && !(ampFault || limitPos || limitNeg) |=> !ampEnable_n) else $error("enable call ignored");
  AST_POWER_OFF: assert property (cmdWr && wb_dat_i[1] && !wb_dat_i[0] |=> ampEnable_n)
    else $error("power-down left output active");
  AST_FAULT_OFF: assert property (ampFault [*6] |-> ampEnable_n)
    else $error("output active during fault");
  AST_RUN_ON: assert property (motionRun |-> !ampEnable_n)
    else $error("run flag without enable");
  AST_STOP_KIND: assert property ((stopDecel || stopAbrupt) |->
    !(stopDecel && stopAbrupt) && !motionRun && !ampEnable_n) else $error("bad stop flags");
  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("bus access not answered");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
endmodule // servo_axis_enable_limit_logic_assertions
bind servo_axis_enable_limit_logic servo_axis_enable_limit_logic_assertions chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .limitPos(limitPos), .limitNeg(limitNeg),
  .ampFault(ampFault), .ampEnable_n(ampEnable_n), .motionRun(motionRun),
  .stopDecel(stopDecel), .stopAbrupt(stopAbrupt));
`default_nettype wire

// *** bench/servo_axis_enable_limit_logic_tb_top.sv ***
// Self-checking bench for the servo axis enable and limit logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module servo_axis_enable_limit_logic_tb_top;
  // ----------
  // Signals
  // ----------
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0;
  logic [31:0] wbRd, rd;
  logic        limitPos = 1'b0;
  logic        limitNeg = 1'b0;
  logic        captPin = 1'b0;
  logic        faultReq = 1'b0;
  logic        stepP = 1'b0;
  logic        stepA = 1'b0;
  logic        stepNeg = 1'b0;
  logic        ack, ampFault, encA, encB, auxA, auxB;
  logic        ampEnable_n, motionRun, stopDecel, stopAbrupt, irq;
  int          fail_count = 0;
  int          cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  servo_axis_enable_limit_logic dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat),
    .wb_dat_o(wbRd), .wb_ack_o(ack), .limitPos(limitPos), .limitNeg(limitNeg),
    .ampFault(ampFault), .coarseHome(1'b0), .captPin(captPin), .encA(encA),
    .encB(encB), .encIdx(1'b0), .auxA(auxA), .auxB(auxB), .ampEnable_n(ampEnable_n),
    .motionRun(motionRun), .stopDecel(stopDecel), .stopAbrupt(stopAbrupt), .irq(irq));
  servo_drive_model prim_u (.clk_sys(clk_sys), .faultReq(faultReq), .stepReq(stepP),
    .stepNeg(stepNeg), .ampFault(ampFault), .phA(encA), .phB(encB));
  servo_drive_model aux_u (.clk_sys(clk_sys), .faultReq(1'b0), .stepReq(stepA),
    .stepNeg(stepNeg), .ampFault(), .phA(auxA), .phB(auxB));
  // ----------
  // Tasks
  // ----------
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Classic single cycle; no fixed answer time is assumed
  // Only the watchdog ends a wait that gets no answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= d;
    do
    begin
      @(posedge clk_sys);
    end
    while (ack !== 1'b1);
    rd = wbRd;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] d);
    xfer(1'b1, servo_axis_pkg::CMD_OFS, d);
    tick(2);
  endtask
  task automatic step(input logic aux, input logic neg, input int k);
    repeat (k)
    begin
      @(posedge clk_sys);
      stepP <= !aux;
      stepA <= aux;
      stepNeg <= neg;
      @(posedge clk_sys);
      stepP <= 1'b0;
      stepA <= 1'b0;
      tick(3);
    end
  endtask
  task automatic pulseCapt;
    @(posedge clk_sys);
    captPin <= 1'b1;
    tick(4);
    captPin <= 1'b0;
    tick(5);
  endtask
  task automatic tReset;
    xfer(1'b0, servo_axis_pkg::CTRL_OFS, 32'h0);
    `CHK(rd[8:0], servo_axis_pkg::CTRL_RESET);
    xfer(1'b1, servo_axis_pkg::STAT_OFS, 32'hffff);
    xfer(1'b0, servo_axis_pkg::STAT_OFS, 32'h0);
    `CHK(rd[5:0], 6'h01);
    xfer(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0);
  endtask
  task automatic tEnable;
    cmd(32'h1);
    `CHK(ampEnable_n, 1'b0);
    `CHK(motionRun, 1'b1);
    cmd(32'h2);
    `CHK(ampEnable_n, 1'b1);
  endtask
  task automatic tFault;
    xfer(1'b1, servo_axis_pkg::IRQ_MASK_OFS, 32'h2);
    cmd(32'h1);
    faultReq <= 1'b1;
    tick(6);
    `CHK(ampEnable_n, 1'b1);
    `CHK(irq, 1'b1);
    xfer(1'b0, servo_axis_pkg::STAT_OFS, 32'h0);
    `CHK(rd[3], 1'b1);
    cmd(32'h1);
    `CHK(ampEnable_n, 1'b1);
    faultReq <= 1'b0;
    tick(6);
    `CHK(ampEnable_n, 1'b1);
    xfer(1'b1, servo_axis_pkg::IRQ_STAT_OFS, 32'hf);
    tick(2);
    `CHK(irq, 1'b0);
    cmd(32'h1);
    `CHK(ampEnable_n, 1'b0);
    cmd(32'h2);
  endtask
  task automatic tLimit;
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b1, servo_axis_pkg::CTRL_OFS, 32'h23 | 32'(m << 2));
      cmd(32'h1);
      limitNeg <= 1'b1;
      tick(5);
      `CHK(stopDecel, m == 0);
      `CHK(stopAbrupt, m == 1 || m == 3);
      `CHK(ampEnable_n, m == 2);
      limitNeg <= 1'b0;
      tick(4);
      cmd(32'h2);
    end
    `CHK(irq, 1'b0);
    xfer(1'b0, servo_axis_pkg::IRQ_STAT_OFS, 32'h0);
    `CHK(rd[0], 1'b1);
    xfer(1'b1, servo_axis_pkg::CTRL_OFS, 32'h20);
    cmd(32'h1);
    limitPos <= 1'b1;
    tick(5);
    `CHK(motionRun, 1'b1);
    xfer(1'b1, servo_axis_pkg::CTRL_OFS, 32'hb3);
    tick(5);
    `CHK(motionRun, 1'b1);
    limitNeg <= 1'b1;
    tick(5);
    `CHK(stopDecel, 1'b1);
    limitPos <= 1'b0;
    limitNeg <= 1'b0;
    tick(4);
    cmd(32'h2);
  endtask
  task automatic tEncoder;
    step(1'b0, 1'b0, 5);
    xfer(1'b0, servo_axis_pkg::POS_OFS, 32'h0);
    `CHK(rd, 32'h5);
    step(1'b0, 1'b1, 7);
    xfer(1'b0, servo_axis_pkg::POS_OFS, 32'h0);
    `CHK(rd, 32'hfffffffe);
    pulseCapt();
    xfer(1'b0, servo_axis_pkg::CAPT_OFS, 32'h0);
    `CHK(rd, 32'hfffffffe);
    xfer(1'b0, servo_axis_pkg::IRQ_STAT_OFS, 32'h0);
    `CHK(rd[2], 1'b1);
    xfer(1'b1, servo_axis_pkg::CTRL_OFS, 32'h63);
    step(1'b1, 1'b0, 3);
    xfer(1'b0, servo_axis_pkg::AUX_OFS, 32'h0);
    `CHK(rd, 32'h3);
    pulseCapt();
    xfer(1'b0, servo_axis_pkg::AUX_OFS, 32'h0);
    `CHK(rd, 32'h0);
  endtask
  task automatic end_sim;
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial
  begin
    tick(2);
    `CHK(ampEnable_n, 1'b1);
    rst_n <= 1'b1;
    tReset();
    tEnable();
    tFault();
    tLimit();
    tEncoder();
    end_sim();
  end
  // Whole run is a few hundred cycles
  initial
  begin
    tick(20000);
    fail_count++;
    end_sim();
  end
endmodule // servo_axis_enable_limit_logic_tb_top
`default_nettype wire

// *** bench/servo_drive_model.sv ***
// Amplifier fault and quadrature encoder model for the servo axis bench
`timescale 1ns/1ps
`default_nettype none
module servo_drive_model (
  // Clock
  input  wire logic clk_sys,
  // Bench requests
  input  wire logic faultReq,
  input  wire logic stepReq,
  input  wire logic stepNeg,
  // Amplifier and encoder lines
  output logic      ampFault,
  output logic      phA,
  output logic      phB
);
  logic [1:0] phase_ff = 2'h0;
  logic       fault_ff = 1'b0;
  // One Gray step per request; phase A leads B going forward
  always @(posedge clk_sys)
  begin
    if (stepReq) phase_ff <= stepNeg ? phase_ff - 2'h1 : phase_ff + 2'h1;
    fault_ff <= faultReq;
  end
  assign ampFault = fault_ff;
  assign phA = phase_ff[1] ^ phase_ff[0];
  assign phB = phase_ff[1];
endmodule // servo_drive_model
`default_nettype wire

// *** core/input_sync.sv ***
// Multi-bit two-stage input synchroniser
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;
  logic [W-1:0] nxt_stage1;
  logic [W-1:0] nxt_stage2;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // two flip-flop stages
  always_comb
  begin
    nxt_stage1 = asyncIn;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign syncOut = stage2_ff;

endmodule // input_sync
`default_nettype wire

// *** core/quad_decoder.sv ***
// Quadrature decoder with index homing, direction output and signed position counter
`timescale 1ns/1ps
`default_nettype none
module quad_decoder (
  // Clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst_n,
  // Synchronised phases
  input  wire logic                              phA,
  input  wire logic                              phB,
  input  wire logic                              idx,
  input  wire logic                              homeOnIdx,
  // Position
  output logic signed [servo_axis_pkg::POS_W-1:0] position,
  output logic                                   dirNeg
);

  logic [1:0]                              prev_ff;
  logic                                    idxPrev_ff;
  logic signed [servo_axis_pkg::POS_W-1:0] pos_ff;
  logic                                    dir_ff;
  logic [1:0]                              nxt_prev;
  logic                                    nxt_idxPrev;
  logic signed [servo_axis_pkg::POS_W-1:0] nxt_pos;
  logic                                    nxt_dir;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // count every single-step transition; double-step transitions are ignored
  always_comb
  begin
    nxt_prev    = {phA, phB};
    nxt_idxPrev = idx;
    nxt_pos     = pos_ff;
    nxt_dir     = dir_ff;
    case ({prev_ff, phA, phB})
      4'b0010, 4'b1011, 4'b1101, 4'b0100:
      begin
        nxt_pos = pos_ff + 32'sd1;
        nxt_dir = 1'b0;
      end
      4'b0001, 4'b0111, 4'b1110, 4'b1000:
      begin
        nxt_pos = pos_ff - 32'sd1;
        nxt_dir = 1'b1;
      end
      default:
      begin
        nxt_pos = pos_ff;
      end
    endcase
    // Index rising edge sets home, taking priority over a count
    if (homeOnIdx && idx && !idxPrev_ff)
    begin
      nxt_pos = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prev_ff    <= 2'h0;
      idxPrev_ff <= 1'b0;
      pos_ff     <= '0;
      dir_ff     <= 1'b0;
    end
    else
    begin
      prev_ff    <= nxt_prev;
      idxPrev_ff <= nxt_idxPrev;
      pos_ff     <= nxt_pos;
      dir_ff     <= nxt_dir;
    end
  end

  assign position = pos_ff;
  assign dirNeg   = dir_ff;

endmodule // quad_decoder
`default_nettype wire

// *** core/servo_axis_enable_limit_logic.sv ***
// Servo axis amplifier enable, limit stopping, fault and feedback logic
// Notes on behaviour
// - Reset drives enable output inactive high
// - Enable call drives enable output low
// - Any axis error deactivates enable output
// - Power-down command deactivates enable output
// - Position mode: stop only toward limit
// - Other modes: stop on either limit
// - Limit stop: decelerate, abrupt or off
// - Disabled limit inputs cause no stopping
// - Capture edge latches current position
// - Auxiliary index sets auxiliary home
// - Decode primary quadrature into position
// - Fault input readable in status word
// - After fault, require clear plus enable
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module servo_axis_enable_limit_logic (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Axis inputs
  input  wire logic        limitPos,
  input  wire logic        limitNeg,
  input  wire logic        ampFault,
  input  wire logic        coarseHome,
  input  wire logic        captPin,
  input  wire logic        encA,
  input  wire logic        encB,
  input  wire logic        encIdx,
  input  wire logic        auxA,
  input  wire logic        auxB,
  // Axis outputs
  output logic             ampEnable_n,
  output logic             motionRun,
  output logic             stopDecel,
  output logic             stopAbrupt,
  output logic             irq
);

  logic        sLimP, sLimN, sFault, sHome, sCapt, sA, sB, sIdx, sAuxA, sAuxB;
  logic signed [31:0] posPrim, posAux;
  logic        dirPrim, dirAux;
  logic [8:0]  ctrl_ff, nxt_ctrl;

  // ----------------------------------------------------------------
  // Input synchronisers and decoders
  // ----------------------------------------------------------------
  // synchronise axis inputs
  input_sync #(.W(10)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .asyncIn ({auxB, auxA, encIdx, encB, encA, captPin, coarseHome, ampFault, limitNeg,
               limitPos}),
    .syncOut ({sAuxB, sAuxA, sIdx, sB, sA, sCapt, sHome, sFault, sLimN, sLimP})
  );

  quad_decoder u_prim (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .phA       (sA),
    .phB       (sB),
    .idx       (sIdx),
    .homeOnIdx (1'b0),
    .position  (posPrim),
    .dirNeg    (dirPrim)
  );

  quad_decoder u_aux (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .phA       (sAuxA),
    .phB       (sAuxB),
    .idx       (sCapt),
    .homeOnIdx (ctrl_ff[servo_axis_pkg::CTRL_PIN_AUX_IDX]),
    .position  (posAux),
    .dirNeg    (dirAux)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0]  irqStat_ff, nxt_irqStat, irqMask_ff, nxt_irqMask;
  logic [31:0] capt_ff, nxt_capt, rdat_ff, nxt_rdat;
  logic        captPrev_ff, nxt_captPrev, ack_ff, nxt_ack, irq_ff, nxt_irq;
  servo_axis_pkg::axis_state_e state_ff, nxt_state;
  logic        ampEn_n_ff, nxt_ampEn_n, run_ff, nxt_run;
  logic        decel_ff, nxt_decel, abrupt_ff, nxt_abrupt;
  logic        faultLatched_ff, nxt_faultLatched;

  logic        wrReq, rdReq, cmdEnable, cmdOff;
  logic        limHit, faultErr, ferrErr, captEdge;
  logic [1:0]  stopMode;
  logic [3:0]  events;
  logic [31:0] ctrlWr;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] laneMerge(input logic [31:0] oldV, input logic [31:0] newV,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wrReq = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign rdReq = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
  assign cmdEnable = wrReq && wb_adr_i == servo_axis_pkg::CMD_OFS && wb_sel_i[0]
                     && wb_dat_i[servo_axis_pkg::CMD_ENABLE];
  assign cmdOff    = wrReq && wb_adr_i == servo_axis_pkg::CMD_OFS && wb_sel_i[0]
                     && wb_dat_i[servo_axis_pkg::CMD_POWEROFF];
  assign stopMode  = ctrl_ff[servo_axis_pkg::CTRL_STOP_LSB +: 2];
  assign captEdge  = sCapt && !captPrev_ff && !ctrl_ff[servo_axis_pkg::CTRL_PIN_AUX_IDX];
  // Merged as a full word; only the low nine bits are kept
  assign ctrlWr    = laneMerge({23'h000000, ctrl_ff}, wb_dat_i, wb_sel_i);

  // ----------------------------------------------------------------
  // Limit and error detection
  // ----------------------------------------------------------------
  always_comb
  begin
    logic lp;
    logic ln;
    lp = sLimP && ctrl_ff[servo_axis_pkg::CTRL_LIM_POS_EN];
    ln = sLimN && ctrl_ff[servo_axis_pkg::CTRL_LIM_NEG_EN];
    if (ctrl_ff[servo_axis_pkg::CTRL_POS_MODE])
    begin
      limHit = (lp && !ctrl_ff[servo_axis_pkg::CTRL_DIR_NEG])
               || (ln && ctrl_ff[servo_axis_pkg::CTRL_DIR_NEG]);
    end
    else
    begin
      limHit = lp || ln;
    end
  end

  assign faultErr = sFault && ctrl_ff[servo_axis_pkg::CTRL_FAULT_SHDN];
  assign ferrErr  = ctrl_ff[servo_axis_pkg::CTRL_FERR];
  assign events   = {ferrErr, captEdge, sFault, limHit};

  // ----------------------------------------------------------------
  // Axis state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state        = state_ff;
    nxt_faultLatched = faultLatched_ff || faultErr;
    case (state_ff)
      servo_axis_pkg::AXIS_OFF:
      begin
        if (cmdEnable && !sFault)
        begin
          nxt_state        = servo_axis_pkg::AXIS_ON;
          nxt_faultLatched = 1'b0;
        end
      end
      servo_axis_pkg::AXIS_ON, servo_axis_pkg::AXIS_STOPPING:
      begin
        if (cmdOff)
        begin
          nxt_state = servo_axis_pkg::AXIS_OFF;
        end
        else if (faultErr || ferrErr)
        begin
          nxt_state = servo_axis_pkg::AXIS_ERROR;
        end
        else if (limHit)
        begin
          if (stopMode == servo_axis_pkg::STOP_OFF)
          begin
            nxt_state = servo_axis_pkg::AXIS_ERROR;
          end
          else
          begin
            nxt_state = servo_axis_pkg::AXIS_STOPPING;
          end
        end
      end
      servo_axis_pkg::AXIS_ERROR:
      begin
        if (cmdEnable && !sFault)
        begin
          nxt_state        = servo_axis_pkg::AXIS_ON;
          nxt_faultLatched = 1'b0;
        end
        else if (cmdOff)
        begin
          nxt_state = servo_axis_pkg::AXIS_OFF;
        end
      end
      default:
      begin
        nxt_state = servo_axis_pkg::AXIS_OFF;
      end
    endcase
    // enable low only while on or stopping
    // error and off states release enable
    nxt_ampEn_n = !(nxt_state == servo_axis_pkg::AXIS_ON
                    || nxt_state == servo_axis_pkg::AXIS_STOPPING);
    nxt_run     = nxt_state == servo_axis_pkg::AXIS_ON;
    nxt_decel   = nxt_state == servo_axis_pkg::AXIS_STOPPING
                  && stopMode == servo_axis_pkg::STOP_DECEL;
    nxt_abrupt  = nxt_state == servo_axis_pkg::AXIS_STOPPING
                  && stopMode != servo_axis_pkg::STOP_DECEL;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_ff        <= servo_axis_pkg::AXIS_OFF;
      ampEn_n_ff      <= 1'b1;
      run_ff          <= 1'b0;
      decel_ff        <= 1'b0;
      abrupt_ff       <= 1'b0;
      faultLatched_ff <= 1'b0;
    end
    else
    begin
      state_ff        <= nxt_state;
      ampEn_n_ff      <= nxt_ampEn_n;
      run_ff          <= nxt_run;
      decel_ff        <= nxt_decel;
      abrupt_ff       <= nxt_abrupt;
      faultLatched_ff <= nxt_faultLatched;
    end
  end

  // ----------------------------------------------------------------
  // Registers and bus
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_ctrl     = ctrl_ff;
    nxt_irqMask  = irqMask_ff;
    nxt_irqStat  = irqStat_ff;
    nxt_capt     = capt_ff;
    nxt_captPrev = sCapt;
    nxt_ack      = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_rdat     = 32'h0000_0000;
    if (wrReq && wb_adr_i == servo_axis_pkg::CTRL_OFS)
    begin
      nxt_ctrl = ctrlWr[8:0];
    end
    if (wrReq && wb_adr_i == servo_axis_pkg::IRQ_MASK_OFS && wb_sel_i[0])
    begin
      nxt_irqMask = wb_dat_i[3:0];
    end
    if (wrReq && wb_adr_i == servo_axis_pkg::IRQ_STAT_OFS && wb_sel_i[0])
    begin
      nxt_irqStat = irqStat_ff & ~wb_dat_i[3:0];
    end
    // Set wins over a same-cycle clear
    nxt_irqStat = nxt_irqStat | events;
    if (captEdge)
    begin
      nxt_capt = posPrim;
    end
    if (rdReq)
    begin
      case (wb_adr_i)
        servo_axis_pkg::CTRL_OFS:     nxt_rdat = {23'h000000, ctrl_ff};
        servo_axis_pkg::STAT_OFS:     nxt_rdat = {22'h000000, dirAux, dirPrim, faultLatched_ff,
                                                  sHome, sLimN, sLimP, sFault, state_ff, ampEn_n_ff};
        servo_axis_pkg::IRQ_STAT_OFS: nxt_rdat = {28'h0000000, irqStat_ff};
        servo_axis_pkg::IRQ_MASK_OFS: nxt_rdat = {28'h0000000, irqMask_ff};
        servo_axis_pkg::POS_OFS:      nxt_rdat = posPrim;
        servo_axis_pkg::CAPT_OFS:     nxt_rdat = capt_ff;
        servo_axis_pkg::AUX_OFS:      nxt_rdat = posAux;
        default:                      nxt_rdat = 32'h0000_0000;
      endcase
    end
    nxt_irq = |(nxt_irqStat & nxt_irqMask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_ff     <= servo_axis_pkg::CTRL_RESET;
      irqMask_ff  <= 4'h0;
      irqStat_ff  <= 4'h0;
      capt_ff     <= 32'h0000_0000;
      captPrev_ff <= 1'b0;
      rdat_ff     <= 32'h0000_0000;
      ack_ff      <= 1'b0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      ctrl_ff     <= nxt_ctrl;
      irqMask_ff  <= nxt_irqMask;
      irqStat_ff  <= nxt_irqStat;
      capt_ff     <= nxt_capt;
      captPrev_ff <= nxt_captPrev;
      rdat_ff     <= nxt_rdat;
      ack_ff      <= nxt_ack;
      irq_ff      <= nxt_irq;
    end
  end

  assign wb_dat_o    = rdat_ff;
  assign wb_ack_o    = ack_ff;
  assign ampEnable_n = ampEn_n_ff;
  assign motionRun   = run_ff;
  assign stopDecel   = decel_ff;
  assign stopAbrupt  = abrupt_ff;
  assign irq         = irq_ff;

endmodule // servo_axis_enable_limit_logic
`default_nettype wire

// *** core/servo_axis_pkg.sv ***
// Package of constants and types for the servo axis enable and limit logic
package servo_axis_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CMD_OFS      = 8'h04;
  localparam logic [7:0] STAT_OFS     = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] POS_OFS      = 8'h14;
  localparam logic [7:0] CAPT_OFS     = 8'h18;
  localparam logic [7:0] AUX_OFS      = 8'h1c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_LIM_POS_EN  = 0;
  localparam int CTRL_LIM_NEG_EN  = 1;
  localparam int CTRL_STOP_LSB    = 2;
  localparam int CTRL_POS_MODE    = 4;
  localparam int CTRL_FAULT_SHDN  = 5;
  localparam int CTRL_PIN_AUX_IDX = 6;
  localparam int CTRL_DIR_NEG     = 7;
  localparam int CTRL_FERR        = 8;
  localparam logic [8:0] CTRL_RESET = 9'h023;

  // Command register bits, write-only pulses
  localparam int CMD_ENABLE   = 0;
  localparam int CMD_POWEROFF = 1;

  // Interrupt event bits
  localparam int EV_LIMIT   = 0;
  localparam int EV_FAULT   = 1;
  localparam int EV_CAPTURE = 2;
  localparam int EV_FERR    = 3;
  localparam int EV_W       = 4;

  // Stop actions for the limit switches
  localparam logic [1:0] STOP_DECEL = 2'h0;
  localparam logic [1:0] STOP_ABRUPT = 2'h1;
  localparam logic [1:0] STOP_OFF   = 2'h2;

  localparam int POS_W  = 32;
  localparam int SYNC_N = 2;

  typedef enum logic [1:0] {AXIS_OFF, AXIS_ON, AXIS_STOPPING, AXIS_ERROR} axis_state_e;

endpackage : servo_axis_pkg
